// >>> bstp_pkg.sv
package bstp_pkg;

	// test port pins as sampled from the board
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} bstp_tap_t;

	// tap controller states, standard encoding
	typedef enum logic [3:0] {
		ST_EXIT2_DR = 4'h0,
		ST_EXIT1_DR = 4'h1,
		ST_SHIFT_DR = 4'h2,
		ST_PAUSE_DR = 4'h3,
		ST_SEL_IR = 4'h4,
		ST_UPDATE_DR = 4'h5,
		ST_CAPTURE_DR = 4'h6,
		ST_SEL_DR = 4'h7,
		ST_EXIT2_IR = 4'h8,
		ST_EXIT1_IR = 4'h9,
		ST_SHIFT_IR = 4'ha,
		ST_PAUSE_IR = 4'hb,
		ST_IDLE = 4'hc,
		ST_UPDATE_IR = 4'hd,
		ST_CAPTURE_IR = 4'he,
		ST_RESET = 4'hf
	} bstp_state_t;

	localparam int IR_LEN = 10;
	localparam logic [IR_LEN-1:0] IR_EXTEST = 10'h000;
	localparam logic [IR_LEN-1:0] IR_SAMPLE = 10'h005;
	localparam logic [IR_LEN-1:0] IR_BYPASS = 10'h3ff;
	localparam logic [IR_LEN-1:0] IR_CONFIG_IO = 10'h00d;
	// serial configuration load
	localparam logic [IR_LEN-1:0] IR_CFG_LOAD = 10'h002;
	// fixed pattern captured into the instruction shifter
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;

	// boundary cells per pin and their order
	localparam int CELLS_PER_PIN = 3;
	localparam int CELL_IN = 0;
	localparam int CELL_OUT = 1;
	localparam int CELL_OE = 2;

	localparam int CFG_W = 8;
	localparam int CFG_DEPTH = 16;
	localparam logic IOSTD_RESET_BIT = 1'b0;

endpackage : bstp_pkg

// >>> bstp_fifo.sv
`timescale 1ns/1ns
module bstp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr;
	logic [AW-1:0] rd;
	logic [AW:0] count;

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW-1:0] next_wr = (wr == AW'(DEPTH - 1)) ? '0 : wr + 1'b1;
	wire [AW-1:0] next_rd = (rd == AW'(DEPTH - 1)) ? '0 : rd + 1'b1;
	wire [AW:0] next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
	// head after this edge; a word written into the head slot is forwarded
	wire [AW-1:0] next_head = pop ? next_rd : rd;
	wire [WIDTH-1:0] next_data = (push && (wr == next_head)) ? in_data : mem[next_head];

	assign in_ready = (count != (AW + 1)'(DEPTH));

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr <= '0;
			rd <= '0;
			count <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			if (push) wr <= next_wr;
			if (pop) rd <= next_rd;
			count <= next_count;
			// registered head keeps the drain side glitch free
			out_valid <= (next_count != '0);
			out_data <= next_data;
		end
	end

endmodule : bstp_fifo

// >>> bstp_tap.sv
`timescale 1ns/1ns
// Summary of operation
// - the test port, its sixteen-state controller and instruction handling follow the 1149.1a-1990 boundary-scan standard.
// - scan tests neither capture nor drive pins while configuration runs, and the controller must not try them then.
// - under the configuration-load instruction the shifted bitstream is packed into bytes and fed to the configuration engine.
// - under the I/O-configuration instruction the standard setting of every pin can be rewritten at any time.
// - sample/preload (00 0000 0101) captures pin values without disturbing the core and latches a pattern for later drive.
// - external test (00 0000 0000) drives the pins from the boundary register and captures input levels into it.
// - bypass (11 1111 1111) passes serial data through a 1-bit register, one test clock late, while the core runs on.
// - pin drivers stay off from reset until configuration has completed, except when the scan logic drives them.
// - the instruction register is ten bits and each code shifted in spans all ten bits.
// - once configuration has completed, an enabled bus-hold or pull-up wins over the high-impedance state that external test would leave.
module bstp_tap #(
	parameter int NPINS = 8,
	parameter int IOSTD_W = 4,
	parameter int FIFO_DEPTH = bstp_pkg::CFG_DEPTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// serial test port
	input wire bstp_pkg::bstp_tap_t TAP,
	output logic TDO,
	output logic TDO_OE,
	// device pins
	input wire logic [NPINS-1:0] PIN_IN,
	output logic [NPINS-1:0] PIN_OUT,
	output logic [NPINS-1:0] PIN_OE,
	output logic [NPINS-1:0] PIN_KEEP,
	output logic [NPINS*IOSTD_W-1:0] IO_STD,
	// user core side
	input wire logic [NPINS-1:0] CORE_OUT,
	input wire logic [NPINS-1:0] CORE_OE,
	input wire logic [NPINS-1:0] KEEP_EN,
	output logic [NPINS-1:0] CORE_IN,
	// configuration engine
	input wire logic CFG_BUSY,
	input wire logic CFG_DONE,
	output logic CFG_HOLD,
	output logic [bstp_pkg::CFG_W-1:0] CFG_DATA,
	output logic CFG_VALID,
	input wire logic CFG_READY
);
	localparam int BSR_LEN = NPINS * bstp_pkg::CELLS_PER_PIN;
	localparam int IOS_LEN = NPINS * IOSTD_W;
	localparam int CW = bstp_pkg::CFG_W;
	localparam int CNT_W = $clog2(CW);

	// two-flop synchronisers; the first stage feeds only the second
	bstp_pkg::bstp_tap_t tap_m;
	bstp_pkg::bstp_tap_t tap_s;
	logic tck_d;
	logic [NPINS-1:0] pin_m;
	logic [NPINS-1:0] pin_s;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tap_m <= '0;
			tap_s <= '0;
			tck_d <= 1'b0;
			pin_m <= '0;
			pin_s <= '0;
		end else begin
			tap_m <= TAP;
			tap_s <= tap_m;
			tck_d <= tap_s.tck;
			pin_m <= PIN_IN;
			pin_s <= pin_m;
		end
	end

	wire tck_rise = tap_s.tck && !tck_d;
	wire tck_fall = !tap_s.tck && tck_d;
	wire trst = !tap_s.trst_n;

	function automatic bstp_pkg::bstp_state_t next_tap(input bstp_pkg::bstp_state_t s, input logic tms);
		case (s)
			bstp_pkg::ST_RESET: next_tap = tms ? bstp_pkg::ST_RESET : bstp_pkg::ST_IDLE;
			bstp_pkg::ST_IDLE: next_tap = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
			bstp_pkg::ST_SEL_DR: next_tap = tms ? bstp_pkg::ST_SEL_IR : bstp_pkg::ST_CAPTURE_DR;
			bstp_pkg::ST_CAPTURE_DR: next_tap = tms ? bstp_pkg::ST_EXIT1_DR : bstp_pkg::ST_SHIFT_DR;
			bstp_pkg::ST_SHIFT_DR: next_tap = tms ? bstp_pkg::ST_EXIT1_DR : bstp_pkg::ST_SHIFT_DR;
			bstp_pkg::ST_EXIT1_DR: next_tap = tms ? bstp_pkg::ST_UPDATE_DR : bstp_pkg::ST_PAUSE_DR;
			bstp_pkg::ST_PAUSE_DR: next_tap = tms ? bstp_pkg::ST_EXIT2_DR : bstp_pkg::ST_PAUSE_DR;
			bstp_pkg::ST_EXIT2_DR: next_tap = tms ? bstp_pkg::ST_UPDATE_DR : bstp_pkg::ST_SHIFT_DR;
			bstp_pkg::ST_UPDATE_DR: next_tap = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
			bstp_pkg::ST_SEL_IR: next_tap = tms ? bstp_pkg::ST_RESET : bstp_pkg::ST_CAPTURE_IR;
			bstp_pkg::ST_CAPTURE_IR: next_tap = tms ? bstp_pkg::ST_EXIT1_IR : bstp_pkg::ST_SHIFT_IR;
			bstp_pkg::ST_SHIFT_IR: next_tap = tms ? bstp_pkg::ST_EXIT1_IR : bstp_pkg::ST_SHIFT_IR;
			bstp_pkg::ST_EXIT1_IR: next_tap = tms ? bstp_pkg::ST_UPDATE_IR : bstp_pkg::ST_PAUSE_IR;
			bstp_pkg::ST_PAUSE_IR: next_tap = tms ? bstp_pkg::ST_EXIT2_IR : bstp_pkg::ST_PAUSE_IR;
			bstp_pkg::ST_EXIT2_IR: next_tap = tms ? bstp_pkg::ST_UPDATE_IR : bstp_pkg::ST_SHIFT_IR;
			bstp_pkg::ST_UPDATE_IR: next_tap = tms ? bstp_pkg::ST_SEL_DR : bstp_pkg::ST_IDLE;
			default: next_tap = bstp_pkg::ST_RESET;
		endcase
	endfunction : next_tap

	// capture image: pin level, core output value, core output enable per pin
	function automatic logic [BSR_LEN-1:0] pack_cells(input logic [NPINS-1:0] pin,
		input logic [NPINS-1:0] val, input logic [NPINS-1:0] oe);
		pack_cells = '0;
		for (int i = 0; i < NPINS; i++) begin
			pack_cells[i*bstp_pkg::CELLS_PER_PIN+bstp_pkg::CELL_IN] = pin[i];
			pack_cells[i*bstp_pkg::CELLS_PER_PIN+bstp_pkg::CELL_OUT] = val[i];
			pack_cells[i*bstp_pkg::CELLS_PER_PIN+bstp_pkg::CELL_OE] = oe[i];
		end
	endfunction : pack_cells

	bstp_pkg::bstp_state_t state;
	logic [bstp_pkg::IR_LEN-1:0] ir_sh;
	logic [bstp_pkg::IR_LEN-1:0] ir;
	logic bypass;
	logic [BSR_LEN-1:0] bsr;
	logic [BSR_LEN-1:0] bsr_upd;
	logic [IOS_LEN-1:0] ios_sh;
	logic [CW-1:0] cfg_sh;
	logic [CNT_W-1:0] cfg_cnt;
	logic cfg_pend;
	logic [CW-1:0] cfg_word;
	logic fifo_ready;

	// decoding of the active instruction
	wire sel_extest = (ir == bstp_pkg::IR_EXTEST);
	wire sel_sample = (ir == bstp_pkg::IR_SAMPLE);
	wire sel_bsr = sel_extest || sel_sample;
	wire sel_io = (ir == bstp_pkg::IR_CONFIG_IO);
	wire sel_cfg = (ir == bstp_pkg::IR_CFG_LOAD);
	wire scan_ok = !CFG_BUSY;
	wire ext_drive = sel_extest && scan_ok;
	wire rise_cap_dr = tck_rise && (state == bstp_pkg::ST_CAPTURE_DR);
	wire rise_sh_dr = tck_rise && (state == bstp_pkg::ST_SHIFT_DR);
	wire fall_upd_dr = tck_fall && (state == bstp_pkg::ST_UPDATE_DR);
	wire fall_upd_ir = tck_fall && (state == bstp_pkg::ST_UPDATE_IR);
	wire shifting = (state == bstp_pkg::ST_SHIFT_IR) || (state == bstp_pkg::ST_SHIFT_DR);
	wire cfg_full = rise_sh_dr && sel_cfg && !cfg_pend && (cfg_cnt == CNT_W'(CW - 1));
	wire tdo_src = (state == bstp_pkg::ST_SHIFT_IR) ? ir_sh[0] :
		sel_bsr ? bsr[0] : sel_io ? ios_sh[0] : bypass;
	wire [BSR_LEN-1:0] cap_img = pack_cells(pin_s, CORE_OUT, CORE_OE);

	// controller and instruction register
	always_ff @(posedge CLK) begin
		if (SYS_RST || trst) begin
			state <= bstp_pkg::ST_RESET;
			ir <= bstp_pkg::IR_BYPASS;
			ir_sh <= bstp_pkg::IR_CAPTURE;
		end else begin
			if (tck_rise) state <= next_tap(state, tap_s.tms);
			if (state == bstp_pkg::ST_RESET) ir <= bstp_pkg::IR_BYPASS;
			else if (fall_upd_ir) ir <= ir_sh;
			if (tck_rise && state == bstp_pkg::ST_CAPTURE_IR) ir_sh <= bstp_pkg::IR_CAPTURE;
			else if (tck_rise && state == bstp_pkg::ST_SHIFT_IR) ir_sh <= {tap_s.tdi, ir_sh[bstp_pkg::IR_LEN-1:1]};
		end
	end

	// data registers; boundary capture and update are held off while configuring
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			bypass <= 1'b0;
			bsr <= '0;
			bsr_upd <= '0;
			ios_sh <= '0;
			IO_STD <= {IOS_LEN{bstp_pkg::IOSTD_RESET_BIT}};
		end else begin
			if (rise_cap_dr) bypass <= 1'b0;
			else if (rise_sh_dr) bypass <= tap_s.tdi;
			if (rise_cap_dr && sel_bsr && scan_ok) bsr <= cap_img;
			else if (rise_sh_dr && sel_bsr) bsr <= {tap_s.tdi, bsr[BSR_LEN-1:1]};
			if (fall_upd_dr && sel_bsr && scan_ok) bsr_upd <= bsr;
			if (rise_cap_dr && sel_io) ios_sh <= IO_STD;
			else if (rise_sh_dr && sel_io) ios_sh <= {tap_s.tdi, ios_sh[IOS_LEN-1:1]};
			if (fall_upd_dr && sel_io) IO_STD <= ios_sh;
		end
	end

	// serial output changes on the falling test clock edge
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			TDO <= 1'b0;
			TDO_OE <= 1'b0;
		end else if (tck_fall) begin
			TDO <= tdo_src;
			TDO_OE <= shifting;
		end
	end

	// bitstream packing, lsb first; bits arriving while a byte waits are dropped
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			cfg_sh <= '0;
			cfg_cnt <= '0;
			cfg_pend <= 1'b0;
			cfg_word <= '0;
		end else begin
			if (rise_sh_dr && sel_cfg && !cfg_pend) begin
				cfg_sh <= {tap_s.tdi, cfg_sh[CW-1:1]};
				cfg_cnt <= cfg_cnt + 1'b1;
			end
			if (cfg_full) begin
				cfg_word <= {tap_s.tdi, cfg_sh[CW-1:1]};
				cfg_pend <= 1'b1;
			end else if (fifo_ready) begin
				cfg_pend <= 1'b0;
			end
			if (rise_cap_dr) cfg_cnt <= '0;
		end
	end

	bstp_fifo #(
		.WIDTH(CW),
		.DEPTH(FIFO_DEPTH)
	) u_cfg_fifo (
		.clk(CLK),
		.rst(SYS_RST),
		.in_valid(cfg_pend),
		.in_ready(fifo_ready),
		.in_data(cfg_word),
		.out_valid(CFG_VALID),
		.out_ready(CFG_READY),
		.out_data(CFG_DATA)
	);

	// per-pin drive selection
	logic [NPINS-1:0] upd_out;
	logic [NPINS-1:0] upd_oe;
	for (genvar gi = 0; gi < NPINS; gi++) begin : g_cell
		assign upd_out[gi] = bsr_upd[gi*bstp_pkg::CELLS_PER_PIN+bstp_pkg::CELL_OUT];
		assign upd_oe[gi] = bsr_upd[gi*bstp_pkg::CELLS_PER_PIN+bstp_pkg::CELL_OE];
	end
	wire [NPINS-1:0] next_out = ext_drive ? upd_out : CORE_OUT;
	wire [NPINS-1:0] next_oe = ext_drive ? upd_oe : (CFG_DONE ? CORE_OE : '0);
	// hold circuits only exist once configured, so keeper follows CFG_DONE
	wire [NPINS-1:0] next_keep = KEEP_EN & ~next_oe & {NPINS{CFG_DONE}};

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PIN_OUT <= '0;
			PIN_OE <= '0;
			PIN_KEEP <= '0;
			CORE_IN <= '0;
			CFG_HOLD <= 1'b0;
		end else begin
			PIN_OUT <= next_out;
			PIN_OE <= next_oe;
			PIN_KEEP <= next_keep;
			CORE_IN <= pin_s;
			CFG_HOLD <= sel_io;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence seq_capture_dr;
		rise_cap_dr;
	endsequence
	sequence seq_update_dr;
		fall_upd_dr;
	endsequence

	a_trst_resets: assert property (trst |=> state == bstp_pkg::ST_RESET)
		else $error("test reset did not force reset state");
	a_bypass_zero: assert property (seq_capture_dr |=> !bypass)
		else $error("bypass bit not cleared in capture");
	a_bypass_delay: assert property (tck_fall && state == bstp_pkg::ST_SHIFT_DR && !sel_bsr && !sel_io |=> TDO == $past(bypass))
		else $error("bypass path not one stage");
	a_ir_capture: assert property (tck_rise && state == bstp_pkg::ST_CAPTURE_IR |=> ir_sh == bstp_pkg::IR_CAPTURE)
		else $error("instruction capture pattern wrong");
	a_sample_cap: assert property (seq_capture_dr and (sel_sample && scan_ok) |=> bsr == $past(cap_img))
		else $error("sample did not capture pins");
	a_busy_blocks: assert property (CFG_BUSY && sel_extest |=> PIN_OE == $past(CFG_DONE ? CORE_OE : '0))
		else $error("scan drive during configuration");
	a_extest_drive: assert property (ext_drive |=> PIN_OUT == $past(upd_out) && PIN_OE == $past(upd_oe))
		else $error("external test drive mismatch");
	a_oe_off_unconf: assert property (!CFG_DONE && !ext_drive |=> PIN_OE == '0)
		else $error("drivers on before configuration");
	a_keeper_wins: assert property (ext_drive && CFG_DONE |=> PIN_KEEP == ($past(KEEP_EN) & ~$past(upd_oe)))
		else $error("keeper lost to high impedance");
	a_iostd_upd: assert property (seq_update_dr and sel_io |=> IO_STD == $past(ios_sh))
		else $error("io standard not updated");
	a_cfg_push: assert property (cfg_full |=> cfg_pend ##0 cfg_word[CW-1] == $past(tap_s.tdi))
		else $error("config byte not presented");
	a_bypass_shift: assert property (rise_sh_dr |=> bypass == $past(tap_s.tdi))
		else $error("bypass bit did not take serial input");
	a_busy_no_cap: assert property (rise_cap_dr && CFG_BUSY |=> $stable(bsr))
		else $error("boundary capture during configuration");
	a_busy_no_upd: assert property (fall_upd_dr && CFG_BUSY |=> $stable(bsr_upd))
		else $error("boundary update during configuration");
	a_tdo_oe_shift: assert property (tck_fall |=> TDO_OE == $past(shifting))
		else $error("serial output enable outside shift");
	a_reset_ir: assert property (state == bstp_pkg::ST_RESET |=> ir == bstp_pkg::IR_BYPASS)
		else $error("instruction not bypass in reset state");
	a_ir_update: assert property (fall_upd_ir && !trst |=> ir == $past(ir_sh))
		else $error("instruction not latched on update");
	a_pend_holds: assert property (cfg_pend && !fifo_ready |=> cfg_pend && $stable(cfg_word))
		else $error("pending config byte lost");
	a_cfg_hold: assert property (sel_io |=> CFG_HOLD)
		else $error("config engine not held under io setup");
	a_core_in: assert property (1'b1 |=> CORE_IN == $past(pin_s))
		else $error("core lost pin levels");
	a_sample_no_drive: assert property (sel_sample |=> PIN_OUT == $past(CORE_OUT))
		else $error("sample disturbed core outputs");

endmodule : bstp_tap

// >>> bstp_ctl_model.sv
`timescale 1ns/1ns
module bstp_ctl_model (
	// clock
	input wire logic clk,
	// test port
	output bstp_pkg::bstp_tap_t tap,
	input wire logic tdo
);
	initial begin
		tap = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
	end

	// one test clock, 8 clk low then 8 high; tdo taken just before the rise
	task automatic tck_bit(input logic tms, input logic tdi, output logic so);
		@(negedge clk);
		tap.tck = 1'b0;
		tap.tms = tms;
		tap.tdi = tdi;
		repeat (8) @(negedge clk);
		so = tdo;
		tap.tck = 1'b1;
		repeat (7) @(negedge clk);
	endtask : tck_bit

	// five ones reach reset from any state, then idle
	task automatic to_idle();
		logic so;
		repeat (5) tck_bit(1'b1, 1'b0, so);
		tck_bit(1'b0, 1'b0, so);
	endtask : to_idle

	// scan from idle back to idle; instruction scans always send all ten bits
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic so;
		dout = '0;
		tck_bit(1'b1, 1'b0, so);
		if (ir) begin
			tck_bit(1'b1, 1'b0, so);
		end
		tck_bit(1'b0, 1'b0, so);
		tck_bit(1'b0, 1'b0, so);
		for (int i = 0; i < n; i++) begin
			tck_bit(i == n - 1, din[i], so);
			dout[i] = so;
		end
		tck_bit(1'b1, ~din[n-1], so);
		tck_bit(1'b0, din[n-1], so);
	endtask : scan

	// test reset pulse; test clock stays put meanwhile
	task automatic pulse_trst();
		@(negedge clk);
		tap.trst_n = 1'b0;
		repeat (6) @(negedge clk);
		tap.trst_n = 1'b1;
		repeat (6) @(negedge clk);
	endtask : pulse_trst
endmodule : bstp_ctl_model

// >>> bstp_tap_tb_top.sv
`timescale 1ns/1ns
module bstp_tap_tb_top;
	logic clk, sys_rst, tdo, tdo_oe, cfg_busy, cfg_done, cfg_hold, cfg_valid, cfg_ready;
	bstp_pkg::bstp_tap_t tap;
	logic [7:0] pin_in, pin_out, pin_oe, pin_keep, core_out, core_oe, keep_en, core_in, cfg_data;
	logic [31:0] io_std, dout;
	int error_cnt, checked;
	localparam logic [23:0] PRE = 24'h9a6c35;
	localparam logic [23:0] NEWP = 24'h53c9e6;

	bstp_tap #(.NPINS(8), .IOSTD_W(4), .FIFO_DEPTH(16)) DUT (
		.CLK(clk), .SYS_RST(sys_rst), .TAP(tap), .TDO(tdo), .TDO_OE(tdo_oe),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_KEEP(pin_keep), .IO_STD(io_std),
		.CORE_OUT(core_out), .CORE_OE(core_oe), .KEEP_EN(keep_en), .CORE_IN(core_in),
		.CFG_BUSY(cfg_busy), .CFG_DONE(cfg_done), .CFG_HOLD(cfg_hold), .CFG_DATA(cfg_data),
		.CFG_VALID(cfg_valid), .CFG_READY(cfg_ready)
	);
	bstp_ctl_model u_ctl (.clk(clk), .tap(tap), .tdo(tdo));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// boundary image: pin level, output value, output enable per pin
	function automatic logic [23:0] cells(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		logic [23:0] r;
		for (int i = 0; i < 8; i++) begin
			r[3*i+:3] = {c[i], b[i], a[i]};
		end
		return r;
	endfunction : cells

	function automatic logic [7:0] pick(input logic [23:0] p, input int k);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i] = p[3*i+k];
		end
		return r;
	endfunction : pick

	task automatic t_reset();
		check(32'(pin_oe), 32'h0000_0000);
		check(io_std, 32'h0000_0000);
		u_ctl.to_idle();
	endtask : t_reset

	task automatic t_bypass();
		u_ctl.scan(1'b1, 10, 32'(bstp_pkg::IR_BYPASS), dout);
		check(dout, 32'(bstp_pkg::IR_CAPTURE));
		u_ctl.scan(1'b0, 8, 32'h0000_00b5, dout);
		check(dout, 32'h0000_006a);
		check(32'(tdo_oe), 32'h0000_0000);
	endtask : t_bypass

	task automatic t_sample();
		cfg_done = 1'b1;
		u_ctl.scan(1'b1, 10, 32'(bstp_pkg::IR_SAMPLE), dout);
		u_ctl.scan(1'b0, 24, 32'(PRE), dout);
		check(dout, 32'(cells(pin_in, core_out, core_oe)));
		check(32'(pin_out), 32'(core_out));
		check(32'(pin_oe), 32'(core_oe));
		check(32'(core_in), 32'(pin_in));
	endtask : t_sample

	task automatic t_extest();
		u_ctl.scan(1'b1, 10, 32'(bstp_pkg::IR_EXTEST), dout);
		check(32'(pin_out), 32'(pick(PRE, bstp_pkg::CELL_OUT)));
		check(32'(pin_oe), 32'(pick(PRE, bstp_pkg::CELL_OE)));
		check(32'(pin_keep), 32'(keep_en & ~pick(PRE, bstp_pkg::CELL_OE)));
		u_ctl.scan(1'b0, 24, 32'(NEWP), dout);
		check(dout, 32'(cells(pin_in, core_out, core_oe)));
		check(32'(pin_oe), 32'(pick(NEWP, bstp_pkg::CELL_OE)));
	endtask : t_extest

	// scan while configuring must leave the update latch alone
	task automatic t_busy();
		cfg_busy = 1'b1;
		cfg_done = 1'b0;
		u_ctl.scan(1'b0, 24, 32'(PRE), dout);
		check(dout, 32'(NEWP));
		check(32'(pin_oe), 32'h0000_0000);
		cfg_busy = 1'b0;
		cfg_done = 1'b1;
		repeat (3) @(negedge clk);
		check(32'(pin_out), 32'(pick(NEWP, bstp_pkg::CELL_OUT)));
		check(32'(pin_oe), 32'(pick(NEWP, bstp_pkg::CELL_OE)));
	endtask : t_busy

	// 18 bytes against a stalled sink: 16 in fifo, one pending, one dropped
	task automatic t_cfg();
		int n;
		u_ctl.scan(1'b1, 10, 32'(bstp_pkg::IR_CFG_LOAD), dout);
		for (int s = 0; s < 6; s++) begin
			u_ctl.scan(1'b0, 24, {8'h00, 8'(8'h42 + 3*s), 8'(8'h41 + 3*s), 8'(8'h40 + 3*s)}, dout);
		end
		for (int k = 0; k < 17; k++) begin
			n = 0;
			while (cfg_valid !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			if (cfg_valid !== 1'b1) begin
				error_cnt++;
				print_verdict();
			end
			check(32'(cfg_data), 32'(8'(8'h40 + k)));
			cfg_ready = 1'b1;
			@(negedge clk);
			cfg_ready = 1'b0;
			@(negedge clk);
		end
		repeat (4) @(negedge clk);
		check(32'(cfg_valid), 32'h0000_0000);
	endtask : t_cfg

	task automatic t_cfgio();
		u_ctl.scan(1'b1, 10, 32'(bstp_pkg::IR_CONFIG_IO), dout);
		check(32'(cfg_hold), 32'h0000_0001);
		u_ctl.scan(1'b0, 32, 32'h5a3c_e1f7, dout);
		check(dout, 32'h0000_0000);
		check(io_std, 32'h5a3c_e1f7);
	endtask : t_cfgio

	// test reset forces bypass but leaves the io standard image alone
	task automatic t_trst();
		u_ctl.pulse_trst();
		check(32'(cfg_hold), 32'h0000_0000);
		check(io_std, 32'h5a3c_e1f7);
		u_ctl.to_idle();
		u_ctl.scan(1'b0, 8, 32'h0000_00b5, dout);
		check(dout, 32'h0000_006a);
	endtask : t_trst

	initial begin
		error_cnt = 0;
		checked = 0;
		sys_rst = 1'b1;
		pin_in = 8'h3c;
		core_out = 8'ha5;
		core_oe = 8'hff;
		keep_en = 8'hff;
		cfg_busy = 1'b0;
		cfg_done = 1'b0;
		cfg_ready = 1'b0;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		t_reset();
		core_oe = 8'h0f;
		t_bypass();
		t_sample();
		t_extest();
		t_busy();
		t_cfg();
		t_cfgio();
		t_trst();
		print_verdict();
	end
endmodule : bstp_tap_tb_top
